// File: verilog/dcfe_pkg.sv
package dcfe_pkg;
  // Avalon word addresses (byte address = 4 * index)
  localparam logic [3:0] ADDR_CMD = 4'h0;
  localparam logic [3:0] ADDR_FEAT = 4'h1;
  localparam logic [3:0] ADDR_PARAM = 4'h2;
  localparam logic [3:0] ADDR_STATUS = 4'h3;
  localparam logic [3:0] ADDR_DATA = 4'h4;
  localparam logic [3:0] ADDR_CAP = 4'h5;
  localparam logic [3:0] ADDR_FEATSTAT = 4'h6;
  localparam logic [3:0] ADDR_SETUP = 4'h7;
  localparam logic [3:0] ADDR_STANDBY = 4'h8;
  localparam logic [3:0] ADDR_COUNT = 4'h9;
  localparam logic [3:0] ADDR_LBA = 4'ha;
  // Command codes
  localparam logic [7:0] CMD_READ = 8'h20;
  localparam logic [7:0] CMD_IDENT = 8'hec;
  localparam logic [7:0] CMD_SETFEAT = 8'hef;
  // Set-features subcommands
  localparam logic [7:0] SF_OFFSET_ON = 8'h09;
  localparam logic [7:0] SF_OFFSET_OFF = 8'h89;
  localparam logic [7:0] SF_PWR_ON_DEF = 8'h05;
  localparam logic [7:0] SF_PWR_OFF_DEF = 8'h85;
  localparam logic [7:0] SF_ACU_ON_DEF = 8'h42;
  localparam logic [7:0] SF_ACU_OFF_DEF = 8'hc2;
  localparam logic [7:0] SF_RLA_ON = 8'haa;
  localparam logic [7:0] SF_RLA_OFF = 8'h55;
  localparam logic [7:0] SF_REVERT_ON = 8'hcc;
  localparam logic [7:0] SF_REVERT_OFF = 8'h66;
  // Level range
  localparam logic [7:0] LVL_MIN = 8'h01;
  localparam logic [7:0] LVL_MAX = 8'hfe;
  localparam logic [7:0] ACU_NO_STANDBY = 8'h80;
  localparam logic [7:0] ACU_RECOMMENDED = 8'h80;
  // Status bits
  localparam int ST_ERR = 0;
  localparam int ST_DRQ = 3;
  localparam int ST_RDY = 6;
  localparam int ST_BSY = 7;
  // Identify word bit positions
  localparam int ID_PWR_BIT = 3;
  localparam int ID_OFS_BIT = 7;
  localparam int ID_ACU_BIT = 9;
  localparam logic [7:0] ID_W83 = 8'd83;
  localparam logic [7:0] ID_W86 = 8'd86;
  localparam logic [7:0] ID_W91 = 8'd91;
  localparam logic [7:0] ID_W94 = 8'd94;
  localparam logic [7:0] ID_W60 = 8'd60;
  localparam logic [7:0] ID_W61 = 8'd61;
  // Sector geometry: 512 bytes as 256 words
  localparam logic [7:0] SECTOR_LAST_WORD = 8'hff;
  // Sector preparation time
  localparam int CLK_NS = 100;
  localparam int PREP_NS = 1000;
  localparam logic [3:0] PREP_CYC = 4'((PREP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [31:0] NATIVE_MAX = 32'h00ffffff;
endpackage

// File: verilog/dcfe_engine.sv
`timescale 1ns/100ps
module dcfe_engine #(
  parameter logic [7:0] SfPwrOn = dcfe_pkg::SF_PWR_ON_DEF,
  parameter logic [7:0] SfPwrOff = dcfe_pkg::SF_PWR_OFF_DEF,
  parameter logic [7:0] SfAcuOn = dcfe_pkg::SF_ACU_ON_DEF,
  parameter logic [7:0] SfAcuOff = dcfe_pkg::SF_ACU_OFF_DEF
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Avalon-MM slave
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Host interrupt and soft reset
  output logic intrq,
  input wire logic softReset,
  // Media side
  input wire logic [15:0] mediaWord,
  input wire logic pwrAlgStandby,
  input wire logic acuAlgStandby,
  output logic standbyReq,
  output logic lookAheadEn,
  output logic [31:0] physLba
);
  typedef enum logic [1:0] {DCFE_IDLE, DCFE_PREP, DCFE_XFER} dcfe_state_e;
  dcfe_state_e state_q, state_d;
  logic bsy_q, bsy_d, drq_q, drq_d, err_q, err_d, irq_q, irq_d;
  logic [7:0] feat_q, feat_d, count_q, count_d, word_q, word_d;
  logic [3:0] prep_q, prep_d;
  logic [7:0] pwrLvl_q, pwrLvl_d, acuLvl_q, acuLvl_d;
  logic pwrEn_q, pwrEn_d, acuEn_q, acuEn_d, ofs_q, ofs_d, rla_q, rla_d, rev_q, rev_d;
  logic [31:0] prot_q, prot_d, setMax_q, setMax_d, lba_q, lba_d, curLba_q, curLba_d;
  logic [31:0] stbyLimit_q, stbyLimit_d, stbyCnt_q, stbyCnt_d, ofsMax_q, ofsMax_d;
  logic [31:0] rdata_q, rdata_d, phys_q, phys_d;
  logic stby_q, stby_d, sr1_q, sr2_q, srPrev_q, identify_q, identify_d;
  logic wait_q, wait_d, la_q, la_d;
  logic [15:0] idWord, dataWord;
  logic srPulse, busy, cmdWr, stsRd, dataRd;

  // Soft reset pin passes a two-stage synchroniser
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sr1_q <= 1'b0;
      sr2_q <= 1'b0;
      srPrev_q <= 1'b0;
    end else begin
      sr1_q <= softReset;
      sr2_q <= sr1_q;
      srPrev_q <= sr2_q;
    end
  end
  assign srPulse = sr2_q & ~srPrev_q;
  assign busy = bsy_q | drq_q;
  // Every access completes after one wait cycle so read data is registered
  assign cmdWr = write & wait_q & (address == dcfe_pkg::ADDR_CMD);
  assign stsRd = read & wait_q & (address == dcfe_pkg::ADDR_STATUS);
  assign dataRd = read & wait_q & (address == dcfe_pkg::ADDR_DATA) & drq_q;
  // Identify image: only feature and capacity words carry content here
  always_comb begin
    idWord = 16'h0000;
    unique case (word_q)
      dcfe_pkg::ID_W83: begin
        idWord[dcfe_pkg::ID_PWR_BIT] = 1'b1;
        idWord[dcfe_pkg::ID_OFS_BIT] = 1'b1;
        idWord[dcfe_pkg::ID_ACU_BIT] = 1'b1;
      end
      dcfe_pkg::ID_W86: begin
        idWord[dcfe_pkg::ID_PWR_BIT] = pwrEn_q;
        idWord[dcfe_pkg::ID_OFS_BIT] = ofs_q;
        idWord[dcfe_pkg::ID_ACU_BIT] = acuEn_q;
      end
      dcfe_pkg::ID_W91: idWord = {8'h00, pwrEn_q ? pwrLvl_q : 8'h00};
      dcfe_pkg::ID_W94: idWord = {dcfe_pkg::ACU_RECOMMENDED, acuEn_q ? acuLvl_q : 8'h00};
      dcfe_pkg::ID_W60: idWord = (ofs_q ? prot_q[15:0] : setMax_q[15:0]);
      dcfe_pkg::ID_W61: idWord = (ofs_q ? prot_q[31:16] : setMax_q[31:16]);
      default: idWord = 16'h0000;
    endcase
  end
  assign dataWord = identify_q ? idWord : mediaWord;

  // Command engine
  always_comb begin
    state_d = state_q;
    bsy_d = bsy_q;
    drq_d = drq_q;
    err_d = err_q;
    irq_d = irq_q;
    feat_d = feat_q;
    count_d = count_q;
    word_d = word_q;
    prep_d = prep_q;
    pwrLvl_d = pwrLvl_q;
    acuLvl_d = acuLvl_q;
    pwrEn_d = pwrEn_q;
    acuEn_d = acuEn_q;
    ofs_d = ofs_q;
    rla_d = rla_q;
    rev_d = rev_q;
    prot_d = prot_q;
    setMax_d = setMax_q;
    lba_d = lba_q;
    curLba_d = curLba_q;
    identify_d = identify_q;
    stbyLimit_d = stbyLimit_q;
    ofsMax_d = ofsMax_q;
    if (stsRd) irq_d = 1'b0;
    if (write & wait_q & ~busy) begin
      unique case (address)
        dcfe_pkg::ADDR_FEAT: feat_d = writedata[7:0];
        dcfe_pkg::ADDR_COUNT: count_d = writedata[7:0];
        dcfe_pkg::ADDR_LBA: lba_d = writedata;
        dcfe_pkg::ADDR_CAP: setMax_d = ofs_q ? setMax_q : writedata;
        dcfe_pkg::ADDR_SETUP: prot_d = writedata;
        dcfe_pkg::ADDR_STANDBY: stbyLimit_d = writedata;
        default: ;
      endcase
      if (ofs_q && address == dcfe_pkg::ADDR_CAP) ofsMax_d = writedata;
    end
    if (cmdWr & ~busy) begin
      irq_d = 1'b0;
      err_d = 1'b0;
      unique case (writedata[7:0])
        dcfe_pkg::CMD_SETFEAT: begin
          irq_d = 1'b1;
          if (feat_q == dcfe_pkg::SF_OFFSET_ON) begin
            if (prot_q == 32'h0) begin
              err_d = 1'b1;
            end else begin
              ofs_d = 1'b1;
              ofsMax_d = prot_q;
            end
          end else if (feat_q == dcfe_pkg::SF_OFFSET_OFF) begin
            ofs_d = 1'b0;
          end else if (feat_q == SfPwrOn) begin
            if (count_q >= dcfe_pkg::LVL_MIN && count_q <= dcfe_pkg::LVL_MAX) begin
              pwrEn_d = 1'b1;
              pwrLvl_d = count_q;
            end else begin
              err_d = 1'b1;
            end
          end else if (feat_q == SfPwrOff) begin
            pwrEn_d = 1'b0;
          end else if (feat_q == SfAcuOn) begin
            if (count_q >= dcfe_pkg::LVL_MIN && count_q <= dcfe_pkg::LVL_MAX) begin
              acuEn_d = 1'b1;
              acuLvl_d = count_q;
            end else begin
              err_d = 1'b1;
            end
          end else if (feat_q == SfAcuOff) begin
            acuEn_d = 1'b0;
          end else if (feat_q == dcfe_pkg::SF_RLA_ON) begin
            rla_d = 1'b1;
          end else if (feat_q == dcfe_pkg::SF_RLA_OFF) begin
            rla_d = 1'b0;
          end else if (feat_q == dcfe_pkg::SF_REVERT_ON) begin
            rev_d = 1'b1;
          end else if (feat_q == dcfe_pkg::SF_REVERT_OFF) begin
            rev_d = 1'b0;
          end else begin
            err_d = 1'b1;
          end
        end
        dcfe_pkg::CMD_IDENT: begin
          identify_d = 1'b1;
          count_d = 8'h01;
          bsy_d = 1'b1;
          prep_d = dcfe_pkg::PREP_CYC;
          state_d = DCFE_PREP;
        end
        dcfe_pkg::CMD_READ: begin
          identify_d = 1'b0;
          curLba_d = lba_q;
          if (count_q == 8'h00 || (ofs_q && lba_q + setMax_q <= dcfe_pkg::NATIVE_MAX
              && lba_q + 32'(count_q) - 32'h1 + setMax_q > dcfe_pkg::NATIVE_MAX)) begin
            err_d = 1'b1;
            irq_d = 1'b1;
          end else if (ofs_q && (lba_q + 32'(count_q) - 32'h1) >= ofsMax_q) begin
            err_d = 1'b1;
            irq_d = 1'b1;
          end else begin
            bsy_d = 1'b1;
            prep_d = dcfe_pkg::PREP_CYC;
            state_d = DCFE_PREP;
          end
        end
        default: begin
          err_d = 1'b1;
          irq_d = 1'b1;
        end
      endcase
    end
    unique case (state_q)
      DCFE_IDLE: ;
      DCFE_PREP: begin
        prep_d = prep_q - 4'h1;
        if (prep_q == 4'h1) begin
          bsy_d = 1'b0;
          drq_d = 1'b1;
          irq_d = 1'b1;
          word_d = 8'h00;
          state_d = DCFE_XFER;
        end
      end
      DCFE_XFER: begin
        if (dataRd) begin
          word_d = word_q + 8'h01;
          if (word_q == dcfe_pkg::SECTOR_LAST_WORD) begin
            drq_d = 1'b0;
            count_d = count_q - 8'h01;
            curLba_d = curLba_q + 32'h1;
            if (count_q == 8'h01) begin
              state_d = DCFE_IDLE;
            end else begin
              bsy_d = 1'b1;
              prep_d = dcfe_pkg::PREP_CYC;
              state_d = DCFE_PREP;
            end
          end
        end
      end
    endcase
    if (srPulse) begin
      state_d = DCFE_IDLE;
      bsy_d = 1'b0;
      drq_d = 1'b0;
      irq_d = 1'b0;
      if (rev_q) ofs_d = 1'b0;
    end
  end
  // Standby timer and trigger combination
  always_comb begin
    stbyCnt_d = stbyCnt_q;
    if (busy || stbyLimit_q == 32'h0) begin
      stbyCnt_d = 32'h0;
    end else if (stbyCnt_q != stbyLimit_q) begin
      stbyCnt_d = stbyCnt_q + 32'h1;
    end
    stby_d = (stbyLimit_q != 32'h0 && stbyCnt_q == stbyLimit_q)
      || (pwrEn_q && pwrAlgStandby)
      || (acuEn_q && acuAlgStandby && acuLvl_q < dcfe_pkg::ACU_NO_STANDBY);
  end

  // Read data and address translation
  always_comb begin
    wait_d = (read | write) & ~wait_q;
    la_d = rla_q & ~ofs_q;
    rdata_d = 32'h0;
    phys_d = curLba_q;
    if (ofs_q) begin
      // Wrap so the low user area stays reachable past the end
      phys_d = (curLba_q + setMax_q > dcfe_pkg::NATIVE_MAX) ?
        curLba_q + setMax_q - dcfe_pkg::NATIVE_MAX - 32'h1 : curLba_q + setMax_q;
    end
    if (read & ~wait_q) begin
      unique case (address)
        dcfe_pkg::ADDR_STATUS: rdata_d = {24'h0, bsy_q, ~bsy_q, 2'b00, drq_q, 2'b00, err_q};
        dcfe_pkg::ADDR_DATA: rdata_d = {16'h0, drq_q ? dataWord : 16'h0000};
        dcfe_pkg::ADDR_CAP: rdata_d = ofs_q ? prot_q : setMax_q;
        dcfe_pkg::ADDR_FEATSTAT: rdata_d = {8'h0, acuLvl_q, pwrLvl_q, 3'b000, rev_q, ofs_q,
          rla_q & ~ofs_q, acuEn_q, pwrEn_q};
        dcfe_pkg::ADDR_SETUP: rdata_d = prot_q;
        dcfe_pkg::ADDR_STANDBY: rdata_d = stbyLimit_q;
        dcfe_pkg::ADDR_COUNT: rdata_d = {24'h0, count_q};
        dcfe_pkg::ADDR_LBA: rdata_d = lba_q;
        default: rdata_d = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= DCFE_IDLE;
      bsy_q <= 1'b0;
      drq_q <= 1'b0;
      err_q <= 1'b0;
      irq_q <= 1'b0;
      feat_q <= 8'h00;
      count_q <= 8'h00;
      word_q <= 8'h00;
      prep_q <= 4'h0;
      pwrLvl_q <= dcfe_pkg::LVL_MAX;
      acuLvl_q <= dcfe_pkg::LVL_MAX;
      pwrEn_q <= 1'b0;
      acuEn_q <= 1'b0;
      ofs_q <= 1'b0;
      rla_q <= 1'b1;
      rev_q <= 1'b0;
      prot_q <= 32'h0;
      setMax_q <= dcfe_pkg::NATIVE_MAX;
      lba_q <= 32'h0;
      curLba_q <= 32'h0;
      identify_q <= 1'b0;
      stbyLimit_q <= 32'h0;
      stbyCnt_q <= 32'h0;
      stby_q <= 1'b0;
      rdata_q <= 32'h0;
      wait_q <= 1'b0;
      phys_q <= 32'h0;
      la_q <= 1'b0;
      ofsMax_q <= 32'h0;
    end else begin
      state_q <= state_d;
      bsy_q <= bsy_d;
      drq_q <= drq_d;
      err_q <= err_d;
      irq_q <= irq_d;
      feat_q <= feat_d;
      count_q <= count_d;
      word_q <= word_d;
      prep_q <= prep_d;
      pwrLvl_q <= pwrLvl_d;
      acuLvl_q <= acuLvl_d;
      pwrEn_q <= pwrEn_d;
      acuEn_q <= acuEn_d;
      ofs_q <= ofs_d;
      rla_q <= rla_d;
      rev_q <= rev_d;
      prot_q <= prot_d;
      setMax_q <= setMax_d;
      lba_q <= lba_d;
      curLba_q <= curLba_d;
      identify_q <= identify_d;
      stbyLimit_q <= stbyLimit_d;
      stbyCnt_q <= stbyCnt_d;
      stby_q <= stby_d;
      rdata_q <= rdata_d;
      wait_q <= wait_d;
      phys_q <= phys_d;
      la_q <= la_d;
      ofsMax_q <= ofsMax_d;
    end
  end

  assign readdata = rdata_q;
  assign waitrequest = ~wait_q;
  assign intrq = irq_q;
  assign standbyReq = stby_q;
  assign lookAheadEn = la_q;
  assign physLba = phys_q;

  busy_held_a: assert property (@(posedge clock) disable iff (!rst_n)
    (state_q != DCFE_IDLE) |-> (bsy_q | drq_q))
    else $error("busy and data-request both low mid-command");
  irq_clear_a: assert property (@(posedge clock) disable iff (!rst_n)
    (stsRd && !(state_q == DCFE_PREP && prep_q == 4'h1)) |=> !irq_q)
    else $error("interrupt survived status read");
  sector_drq_a: assert property (@(posedge clock) disable iff (!rst_n)
    (state_q == DCFE_PREP && prep_q == 4'h1 && !srPulse) |=> (drq_q && !bsy_q && irq_q))
    else $error("sector ready without data-request and interrupt");
  offset_abort_a: assert property (@(posedge clock) disable iff (!rst_n)
    (cmdWr && !busy && writedata[7:0] == dcfe_pkg::CMD_SETFEAT
      && feat_q == dcfe_pkg::SF_OFFSET_ON && prot_q == 32'h0 && !ofs_q) |=> (err_q && !ofs_q))
    else $error("offset enable without protected area not aborted");
  offset_exit_a: assert property (@(posedge clock) disable iff (!rst_n)
    (cmdWr && !busy && writedata[7:0] == dcfe_pkg::CMD_SETFEAT
      && feat_q == dcfe_pkg::SF_OFFSET_OFF) |=> !ofs_q)
    else $error("offset mode not left");
  acu_standby_a: assert property (@(posedge clock) disable iff (!rst_n)
    (acuLvl_q >= dcfe_pkg::ACU_NO_STANDBY && !pwrAlgStandby && stbyLimit_q == 32'h0)
      |=> !stby_q)
    else $error("acoustic standby at high level");
  lookahead_off_a: assert property (@(posedge clock) disable iff (!rst_n)
    ofs_q |=> !lookAheadEn)
    else $error("look-ahead while offset active");
  busy_cmd_a: assert property (@(posedge clock) disable iff (!rst_n)
    (cmdWr && busy && !srPulse) |=> $stable(pwrEn_q) && $stable(ofs_q))
    else $error("command taken while busy");
endmodule

// File: sim/dcfe_media_model.sv
`timescale 1ns/100ps
module dcfe_media_model (
  // Engine side
  input wire logic [31:0] physLba,
  output logic [15:0] mediaWord,
  output logic pwrAlgStandby,
  output logic acuAlgStandby,
  // Bench controls
  input wire logic pwrWant,
  input wire logic acuWant
);
  // Data carries its sector address, so a wrong translation shows in the data
  assign mediaWord = physLba[15:0] ^ 16'h5a5a;
  assign pwrAlgStandby = pwrWant;
  assign acuAlgStandby = acuWant;
endmodule

// File: sim/test_disk_command_feature_engine.sv
`timescale 1ns/100ps
module test_disk_command_feature_engine;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] address = 4'h0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic waitrequest;
  logic intrq;
  logic softReset = 1'b0;
  logic [15:0] mediaWord;
  logic pwrAlgStandby;
  logic acuAlgStandby;
  logic standbyReq;
  logic lookAheadEn;
  logic [31:0] physLba;
  logic pwrWant = 1'b0;
  logic acuWant = 1'b0;
  logic [15:0] words [256];
  logic [7:0] lv [4] = '{8'h01, 8'hfe, 8'h00, 8'hff};
  logic [31:0] r;
  int n_fail = 0;
  int compares = 0;
  int cycles = 0;

  always #50 clock = ~clock;

  dcfe_engine dut (
    .clock(clock), .rst_n(rst_n), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .intrq(intrq), .softReset(softReset), .mediaWord(mediaWord),
    .pwrAlgStandby(pwrAlgStandby), .acuAlgStandby(acuAlgStandby),
    .standbyReq(standbyReq), .lookAheadEn(lookAheadEn), .physLba(physLba)
  );

  dcfe_media_model media (
    .physLba(physLba), .mediaWord(mediaWord), .pwrAlgStandby(pwrAlgStandby),
    .acuAlgStandby(acuAlgStandby), .pwrWant(pwrWant), .acuWant(acuWant)
  );

  task automatic conclude();
    if (n_fail == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Whole run is near 5300 cycles
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      conclude();
    end
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Waitrequest is read before the edge's own updates land
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    address <= a;
    writedata <= d;
    write <= 1'b1;
    do @(posedge clock); while (waitrequest !== 1'b0);
    write <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clock);
    address <= a;
    read <= 1'b1;
    do @(posedge clock); while (waitrequest !== 1'b0);
    d = readdata;
    read <= 1'b0;
  endtask

  task automatic setFeat(input logic [7:0] sub, input logic [7:0] lvl, input logic err);
    wr(dcfe_pkg::ADDR_COUNT, {24'h0, lvl});
    wr(dcfe_pkg::ADDR_FEAT, {24'h0, sub});
    wr(dcfe_pkg::ADDR_CMD, {24'h0, dcfe_pkg::CMD_SETFEAT});
    repeat (2) @(posedge clock);
    check("sfIrq", intrq, 1'b1);
    rd(dcfe_pkg::ADDR_STATUS, r);
    check("sfErr", r[dcfe_pkg::ST_ERR], err);
    repeat (2) @(posedge clock);
    check("irqClr", intrq, 1'b0);
  endtask

  task automatic cmd(input logic [7:0] c, input logic [31:0] lba, input logic [7:0] cnt);
    wr(dcfe_pkg::ADDR_LBA, lba);
    wr(dcfe_pkg::ADDR_COUNT, {24'h0, cnt});
    wr(dcfe_pkg::ADDR_CMD, {24'h0, c});
    rd(dcfe_pkg::ADDR_STATUS, r);
    check("busyHeld", r[dcfe_pkg::ST_BSY] | r[dcfe_pkg::ST_DRQ], 1'b1);
  endtask

  task automatic sector();
    while (intrq !== 1'b1) @(posedge clock);
    rd(dcfe_pkg::ADDR_STATUS, r);
    check("drqUp", r[7:0] & 8'h89, 8'h08);
    for (int i = 0; i < 256; i++) begin
      rd(dcfe_pkg::ADDR_DATA, r);
      words[i] = r[15:0];
    end
    check("wordHigh", r[31:16], 16'h0);
    rd(dcfe_pkg::ADDR_STATUS, r);
    check("drqDown", r[dcfe_pkg::ST_DRQ], 1'b0);
  endtask

  initial begin
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    repeat (3) @(posedge clock);
    check("irqRst", intrq, 1'b0);
    check("laRst", lookAheadEn, 1'b1);
    rd(dcfe_pkg::ADDR_STATUS, r);
    check("ready", r[7:6], 2'b01);
    wr(4'h2, 32'h1234);
    rd(4'h2, r);
    check("unmapped", r, 32'h0);
    // Both ends of the level range, then the two codes just outside it
    for (int f = 0; f < 2; f++) begin
      for (int k = 0; k < 4; k++) begin
        setFeat(f ? dcfe_pkg::SF_ACU_ON_DEF : dcfe_pkg::SF_PWR_ON_DEF, lv[k], k[1]);
        rd(dcfe_pkg::ADDR_FEATSTAT, r);
        check("level", f ? r[23:16] : r[15:8], k ? 8'hfe : 8'h01);
        check("featOn", r[f], 1'b1);
      end
    end
    setFeat(dcfe_pkg::SF_PWR_ON_DEF, 8'h40, 1'b0);
    setFeat(dcfe_pkg::SF_ACU_ON_DEF, 8'h7f, 1'b0);
    acuWant <= 1'b1;
    repeat (3) @(posedge clock);
    check("acuSb", standbyReq, 1'b1);
    setFeat(dcfe_pkg::SF_ACU_ON_DEF, dcfe_pkg::ACU_NO_STANDBY, 1'b0);
    check("acuQuiet", standbyReq, 1'b0);
    rd(dcfe_pkg::ADDR_FEATSTAT, r);
    check("pwrKept", r[15:8], 8'h40);
    pwrWant <= 1'b1;
    repeat (3) @(posedge clock);
    check("pwrSb", standbyReq, 1'b1);
    setFeat(dcfe_pkg::SF_PWR_OFF_DEF, 8'h40, 1'b0);
    check("pwrOff", standbyReq, 1'b0);
    setFeat(dcfe_pkg::SF_ACU_ON_DEF, 8'h7f, 1'b0);
    setFeat(dcfe_pkg::SF_ACU_OFF_DEF, 8'h7f, 1'b0);
    check("acuOff", standbyReq, 1'b0);
    pwrWant <= 1'b0;
    acuWant <= 1'b0;
    wr(dcfe_pkg::ADDR_STANDBY, 32'd20);
    for (int i = 0; i < 60 && standbyReq !== 1'b1; i++) @(posedge clock);
    check("timerSb", standbyReq, 1'b1);
    wr(dcfe_pkg::ADDR_STANDBY, 32'd0);
    setFeat(dcfe_pkg::SF_PWR_ON_DEF, 8'h40, 1'b0);
    setFeat(dcfe_pkg::SF_ACU_ON_DEF, 8'h90, 1'b0);
    cmd(dcfe_pkg::CMD_IDENT, 32'h0, 8'h1);
    sector();
    check("w83", words[83] & 16'h0288, 16'h0288);
    check("w86", words[86] & 16'h0288, 16'h0208);
    check("w91", words[91][7:0], 8'h40);
    check("w94", words[94], 16'h8090);
    // A command written while busy must leave the power feature alone
    wr(dcfe_pkg::ADDR_FEAT, {24'h0, dcfe_pkg::SF_PWR_OFF_DEF});
    cmd(dcfe_pkg::CMD_READ, 32'h20, 8'h2);
    wr(dcfe_pkg::ADDR_CMD, {24'h0, dcfe_pkg::CMD_SETFEAT});
    for (int s = 0; s < 2; s++) begin
      sector();
      check("data0", words[0], 16'h5a5a ^ (16'h20 + s[15:0]));
      check("dataEnd", words[255], 16'h5a5a ^ (16'h20 + s[15:0]));
    end
    rd(dcfe_pkg::ADDR_FEATSTAT, r);
    check("cmdIgnored", r[0], 1'b1);
    setFeat(dcfe_pkg::SF_OFFSET_ON, 8'h0, 1'b1);
    rd(dcfe_pkg::ADDR_FEATSTAT, r);
    check("ofsStay", r[3], 1'b0);
    wr(dcfe_pkg::ADDR_SETUP, 32'h40);
    wr(dcfe_pkg::ADDR_CAP, 32'h1000);
    setFeat(dcfe_pkg::SF_OFFSET_ON, 8'h0, 1'b0);
    rd(dcfe_pkg::ADDR_FEATSTAT, r);
    check("ofsOn", r[3], 1'b1);
    check("laOff", lookAheadEn, 1'b0);
    rd(dcfe_pkg::ADDR_CAP, r);
    check("capOfs", r, 32'h40);
    cmd(dcfe_pkg::CMD_READ, 32'h3, 8'h1);
    sector();
    check("ofsData", words[0], 16'h5a5a ^ 16'h1003);
    // Range ends at the protected size, past the offset-mode limit
    wr(dcfe_pkg::ADDR_LBA, 32'h3f);
    wr(dcfe_pkg::ADDR_COUNT, 32'h2);
    wr(dcfe_pkg::ADDR_CMD, {24'h0, dcfe_pkg::CMD_READ});
    while (intrq !== 1'b1) @(posedge clock);
    rd(dcfe_pkg::ADDR_STATUS, r);
    check("ofsLimit", {r[dcfe_pkg::ST_ERR], r[dcfe_pkg::ST_DRQ]}, 2'b10);
    // Set-max lifts the offset-mode limit, yet a range across the native end still fails
    wr(dcfe_pkg::ADDR_CAP, 32'h01000000);
    cmd(dcfe_pkg::CMD_READ, 32'h40, 8'h1);
    sector();
    check("ofsLifted", words[0], 16'h5a5a ^ 16'h1040);
    wr(dcfe_pkg::ADDR_LBA, 32'h00ffefff);
    wr(dcfe_pkg::ADDR_COUNT, 32'h2);
    wr(dcfe_pkg::ADDR_CMD, {24'h0, dcfe_pkg::CMD_READ});
    while (intrq !== 1'b1) @(posedge clock);
    rd(dcfe_pkg::ADDR_STATUS, r);
    check("nativeCross", {r[dcfe_pkg::ST_ERR], r[dcfe_pkg::ST_DRQ]}, 2'b10);
    cmd(dcfe_pkg::CMD_IDENT, 32'h0, 8'h1);
    sector();
    check("w86ofs", words[86][7], 1'b1);
    check("w60ofs", words[60], 16'h40);
    setFeat(dcfe_pkg::SF_OFFSET_OFF, 8'h0, 1'b0);
    rd(dcfe_pkg::ADDR_CAP, r);
    check("capBack", r, 32'h1000);
    check("laBack", lookAheadEn, 1'b1);
    for (int v = 0; v < 2; v++) begin
      setFeat(v ? dcfe_pkg::SF_REVERT_OFF : dcfe_pkg::SF_REVERT_ON, 8'h0, 1'b0);
      setFeat(dcfe_pkg::SF_OFFSET_ON, 8'h0, 1'b0);
      softReset <= 1'b1;
      repeat (4) @(posedge clock);
      softReset <= 1'b0;
      repeat (6) @(posedge clock);
      rd(dcfe_pkg::ADDR_FEATSTAT, r);
      check("softOfs", r[3], v[0]);
    end
    conclude();
  end
endmodule
